// ==== design/somsel_regs.vh ====
`ifndef SOMSEL_REGS_VH
`define SOMSEL_REGS_VH
// ==========================================
// Register byte offsets
`define SOMSEL_OFS_MODE_SEL 8'h00
`define SOMSEL_OFS_STARTUP 8'h04
`define SOMSEL_OFS_CTRL 8'h08
`define SOMSEL_OFS_STATUS 8'h0C
`define SOMSEL_OFS_INPUTS 8'h10
// ==========================================
// Reset values
`define SOMSEL_MODE_SEL_RST 8'h00
`define SOMSEL_STARTUP_RST 8'h00
// ==========================================
// Setting values
`define SOMSEL_SU_CFG 8'h00
`define SOMSEL_SU_NET 8'h01
`define SOMSEL_SU_PNET 8'h0A
// ==========================================
// Operation mode codes
`define SOMSEL_OP_EXT 2'h0
`define SOMSEL_OP_PANEL 2'h1
`define SOMSEL_OP_NET 2'h2
`define SOMSEL_OP_COMB 2'h3
// ==========================================
// Control register bit positions
`define SOMSEL_CTRL_KEY 0
`define SOMSEL_CTRL_PNET_EN 1
`define SOMSEL_CTRL_NETEXT_EN 2
`define SOMSEL_CTRL_EXTPNL_EN 3
`define SOMSEL_CTRL_REQ_LSB 4
`define SOMSEL_CTRL_REQ_STB 6
// AXI responses
`define SOMSEL_RESP_OKAY 2'h0
`define SOMSEL_RESP_SLVERR 2'h2
`endif

// ==== design/somsel_sync.v ====
`timescale 1ns/10ps
// ==========================================
// Three-stage synchroniser, change accepted once stages two and three agree
module somsel_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Data
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
    end
  end
endmodule

// ==== design/somsel_axil.v ====
`timescale 1ns/10ps
`include "somsel_regs.vh"
// ==========================================
// AXI4-Lite slave front end: one write and one read in flight
module somsel_axil (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // Write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core side
  output reg wr_stb,
  output reg [7:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_err,
  output reg rd_stb,
  output reg [7:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_err
);
  reg aw_have_q;
  reg w_have_q;
  reg wpend_q;
  reg rpend_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SOMSEL_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SOMSEL_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wpend_q <= 1'b0;
      rpend_q <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      rd_stb <= 1'b0;
      rd_addr <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_q && w_have_q && !wpend_q) begin
        wr_stb <= 1'b1;
        wpend_q <= 1'b1;
      end
      // Response one cycle after the strobe, so the error flag is settled
      if (wpend_q && wr_stb) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `SOMSEL_RESP_SLVERR : `SOMSEL_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        wpend_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= s_axi_araddr;
        rd_stb <= 1'b1;
        rpend_q <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (rpend_q && rd_stb) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? `SOMSEL_RESP_SLVERR : `SOMSEL_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        rpend_q <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ==== design/somsel_top.v ====
`timescale 1ns/10ps
`include "somsel_regs.vh"
module somsel_top (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Power events
  input wire power_on_evt,
  input wire power_restore_evt,
  // Drive state
  input wire drive_running,
  // Terminal inputs, asynchronous
  input wire output_stop_input,
  input wire panel_network_switch_input,
  input wire network_external_switch_input,
  input wire external_panel_switch_input,
  // Panel key, asynchronous
  input wire panel_mode_key,
  // AXI4-Lite
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Mode outputs
  output reg [1:0] op_mode,
  output reg net_cmd_enable
);
  wire [4:0] sync_v;
  wire stop_s = sync_v[0];
  wire pnet_s = sync_v[1];
  wire netext_s = sync_v[2];
  wire extpnl_s = sync_v[3];
  wire key_s = sync_v[4];
  wire wr_stb;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_stb;
  wire [7:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_err;
  reg wr_err;
  reg [7:0] mode_sel_q;
  reg [7:0] startup_q;
  reg pnet_en_q;
  reg netext_en_q;
  reg extpnl_en_q;
  reg key_d1_q;
  reg pnet_d1_q;
  reg eval_q;
  reg last_refused_q;
  reg [1:0] req_mode;
  reg req_stb;
  reg [1:0] mode_d;

  // ==========================================
  // Input synchronisers
  somsel_sync #(
    .W(5)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .async_in({panel_mode_key, external_panel_switch_input, network_external_switch_input,
      panel_network_switch_input, output_stop_input}),
    .sync_out(sync_v)
  );

  // ==========================================
  // Bus front end
  somsel_axil u_axil (
    .clk_sys(clk_sys),
    .srst(srst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ==========================================
  // Setting checks
  function sel_legal;
    input [7:0] v;
    begin
      sel_legal = (v <= 8'h04) || (v == 8'h06) || (v == 8'h07);
    end
  endfunction

  function su_legal;
    input [7:0] v;
    begin
      su_legal = (v == `SOMSEL_SU_CFG) || (v == `SOMSEL_SU_NET) || (v == `SOMSEL_SU_PNET);
    end
  endfunction

  // Panel/network pair active under startup 10
  function pnet_mode;
    input [7:0] sel;
    input [7:0] su;
    begin
      pnet_mode = (su == `SOMSEL_SU_PNET) && ((sel == 8'h00) || (sel == 8'h06));
    end
  endfunction

  // ==========================================
  // Register writes
  wire wr_sel = wr_stb && (wr_addr == `SOMSEL_OFS_MODE_SEL);
  wire wr_su = wr_stb && (wr_addr == `SOMSEL_OFS_STARTUP);
  wire wr_ctl = wr_stb && (wr_addr == `SOMSEL_OFS_CTRL);
  wire wr_known = wr_sel || wr_su || wr_ctl;

  always @* begin
    wr_err = 1'b0;
    if (wr_stb) begin
      if (!wr_known) begin
        wr_err = 1'b1;
      end else if (wr_sel && (drive_running || !sel_legal(wr_data[7:0]) || !wr_strb[0])) begin
        wr_err = 1'b1;
      end else if (wr_su && (drive_running || !su_legal(wr_data[7:0]) || !wr_strb[0])) begin
        wr_err = 1'b1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      mode_sel_q <= `SOMSEL_MODE_SEL_RST;
      startup_q <= `SOMSEL_STARTUP_RST;
      pnet_en_q <= 1'b0;
      netext_en_q <= 1'b0;
      extpnl_en_q <= 1'b0;
    end else if (!wr_err) begin
      if (wr_sel) begin
        mode_sel_q <= wr_data[7:0];
      end
      if (wr_su) begin
        startup_q <= wr_data[7:0];
      end
      if (wr_ctl && wr_strb[0]) begin
        pnet_en_q <= wr_data[`SOMSEL_CTRL_PNET_EN];
        netext_en_q <= wr_data[`SOMSEL_CTRL_NETEXT_EN];
        extpnl_en_q <= wr_data[`SOMSEL_CTRL_EXTPNL_EN];
      end
    end
  end

  // ==========================================
  // Software mode requests and the panel key
  wire sw_key = wr_ctl && wr_strb[0] && wr_data[`SOMSEL_CTRL_KEY];
  wire key_edge = (key_s && !key_d1_q) || sw_key;
  wire pnet_chg = pnet_en_q && (pnet_s != pnet_d1_q);
  wire sw_req = wr_ctl && wr_strb[0] && wr_data[`SOMSEL_CTRL_REQ_STB];

  always @* begin
    req_mode = wr_data[`SOMSEL_CTRL_REQ_LSB+1:`SOMSEL_CTRL_REQ_LSB];
    req_stb = sw_req;
  end

  // ==========================================
  // Mode decision
  wire start_net = (startup_q != `SOMSEL_SU_CFG) && (mode_sel_q != 8'h01) && (mode_sel_q != 8'h03) &&
    (mode_sel_q != 8'h04) && !(mode_sel_q == 8'h07 && (startup_q == `SOMSEL_SU_PNET || !stop_s));
  wire pair = pnet_mode(mode_sel_q, startup_q);
  wire can_switch = (mode_sel_q == 8'h06) || !drive_running;

  always @* begin
    mode_d = op_mode;
    if (eval_q) begin
      if (mode_sel_q == 8'h01) begin
        mode_d = `SOMSEL_OP_PANEL;
      end else if (mode_sel_q == 8'h03 || mode_sel_q == 8'h04) begin
        mode_d = `SOMSEL_OP_COMB;
      end else if (start_net) begin
        mode_d = `SOMSEL_OP_NET;
      end else begin
        mode_d = `SOMSEL_OP_EXT;
      end
    end else if (mode_sel_q == 8'h01) begin
      mode_d = `SOMSEL_OP_PANEL;
    end else if (mode_sel_q == 8'h03 || mode_sel_q == 8'h04) begin
      mode_d = `SOMSEL_OP_COMB;
    end else if (mode_sel_q == 8'h07 && !stop_s) begin
      mode_d = `SOMSEL_OP_EXT;
    end else if (pair && mode_sel_q == 8'h02) begin
      mode_d = `SOMSEL_OP_NET;
    end else if (startup_q == `SOMSEL_SU_PNET && mode_sel_q == 8'h02) begin
      mode_d = `SOMSEL_OP_NET;
    end else if (can_switch) begin
      if (netext_en_q && !pair) begin
        mode_d = netext_s ? `SOMSEL_OP_NET : (extpnl_en_q && !extpnl_s && mode_sel_q != 8'h02) ?
          `SOMSEL_OP_PANEL : `SOMSEL_OP_EXT;
      end else if (pair) begin
        if (pnet_chg) begin
          mode_d = pnet_s ? `SOMSEL_OP_PANEL : `SOMSEL_OP_NET;
        end else if (key_edge) begin
          mode_d = (op_mode == `SOMSEL_OP_NET) ? `SOMSEL_OP_PANEL : `SOMSEL_OP_NET;
        end
      end else if (req_stb) begin
        // Three-way switching: panel and network only meet via External
        if (req_mode == `SOMSEL_OP_EXT) begin
          mode_d = `SOMSEL_OP_EXT;
        end else if (req_mode == `SOMSEL_OP_PANEL && op_mode == `SOMSEL_OP_EXT && mode_sel_q != 8'h02) begin
          mode_d = `SOMSEL_OP_PANEL;
        end else if (req_mode == `SOMSEL_OP_NET && op_mode == `SOMSEL_OP_EXT) begin
          mode_d = `SOMSEL_OP_NET;
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      op_mode <= `SOMSEL_OP_EXT;
      net_cmd_enable <= 1'b0;
      key_d1_q <= 1'b0;
      pnet_d1_q <= 1'b0;
      eval_q <= 1'b1;
      last_refused_q <= 1'b0;
    end else begin
      eval_q <= power_on_evt || power_restore_evt;
      op_mode <= mode_d;
      net_cmd_enable <= (mode_d == `SOMSEL_OP_NET);
      key_d1_q <= key_s;
      pnet_d1_q <= pnet_s;
      if (req_stb) begin
        last_refused_q <= (mode_d != req_mode);
      end
    end
  end

  // ==========================================
  // Register reads
  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (rd_addr)
      `SOMSEL_OFS_MODE_SEL: rd_data = {24'h000000, mode_sel_q};
      `SOMSEL_OFS_STARTUP: rd_data = {24'h000000, startup_q};
      `SOMSEL_OFS_CTRL: rd_data = {28'h0000000, extpnl_en_q, netext_en_q, pnet_en_q, 1'b0};
      `SOMSEL_OFS_STATUS: rd_data = {28'h0000000, last_refused_q, net_cmd_enable, op_mode};
      `SOMSEL_OFS_INPUTS: rd_data = {27'h0000000, key_s, extpnl_s, netext_s, pnet_s, stop_s};
      default: rd_err = 1'b1;
    endcase
  end
endmodule

// ==== test/somsel_monitor.sv ====
`timescale 1ns/10ps
// ==========================================
// Port checker
module somsel_monitor (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Drive state
  input wire drive_running,
  // AXI4-Lite
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  // Mode outputs
  input wire [1:0] op_mode,
  input wire net_cmd_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  endsequence
  sequence s_slverr;
    s_axi_bvalid && s_axi_bresp == 2'h2;
  endsequence
  property p_net_en;
    net_cmd_enable == (op_mode == 2'h2);
  endproperty
  a_net_en: assert property (p_net_en) else $error("net enable disagrees with mode");
  // Own disable so the reset values themselves are checked
  property p_reset;
    disable iff (1'b0) srst |=> op_mode == 2'h0 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_b_lat;
    s_wr_both |=> !s_axi_bvalid [*2] ##1 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late or early");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late or early");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10 |-> ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_run_refuse;
    s_wr_both ##0 (s_axi_awaddr < 8'h08 && drive_running) ##1 drive_running [*2] |=> s_slverr;
  endproperty
  a_run_refuse: assert property (p_run_refuse) else $error("setting written while running");
  property p_bad_sel;
    s_wr_both ##0 (s_axi_awaddr == 8'h00 && (s_axi_wdata[7:0] == 8'h05 || s_axi_wdata[7:0] > 8'h07)) |-> ##3 s_slverr;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("illegal mode select accepted");
  property p_bad_su;
    s_wr_both ##0 (s_axi_awaddr == 8'h04 && !(s_axi_wdata[7:0] inside {8'h00, 8'h01, 8'h0A})) |-> ##3 s_slverr;
  endproperty
  a_bad_su: assert property (p_bad_su) else $error("illegal startup value accepted");
endmodule
bind somsel_top somsel_monitor i_mon (.*);

// ==== test/somsel_axi_master.sv ====
`timescale 1ns/10ps
// ==========================================
// Panel and network master: register bus and panel key
module somsel_axi_master (
  // Clock
  input wire clk_sys,
  // AXI4-Lite master
  output reg [7:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg [3:0] s_axi_wstrb,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  output reg [7:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready,
  // Panel
  output reg panel_mode_key
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = 47'h0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, panel_mode_key} = 11'h0;
  end
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    begin
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      #1;
      // Each channel released only at its own handshake edge
      while (s_axi_awvalid || s_axi_wvalid) begin
        @(posedge clk_sys);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        #1;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  // Held long enough to pass the input synchroniser
  task key_press;
    begin
      @(posedge clk_sys);
      panel_mode_key <= 1'b1;
      repeat (10) @(posedge clk_sys);
      panel_mode_key <= 1'b0;
      repeat (10) @(posedge clk_sys);
    end
  endtask
endmodule

// ==== test/startup_operation_mode_select_tb_top.sv ====
`timescale 1ns/10ps
`include "somsel_regs.vh"
module startup_operation_mode_select_tb_top;
  // {startup, select, stop, expected mode}
  localparam [335:0] TBL = {16'h0000, 16'h0011, 16'h0020, 16'h0033, 16'h0043, 16'h0060, 16'h0078,
    16'h0070, 16'h0102, 16'h0111, 16'h0122, 16'h0133, 16'h0162, 16'h017A, 16'h0170, 16'h0A02,
    16'h0A11, 16'h0A22, 16'h0A33, 16'h0A62, 16'h0A70};
  reg clk_sys, srst, power_on_evt, power_restore_evt, drive_running;
  reg output_stop_input, panel_network_switch_input, network_external_switch_input, external_panel_switch_input;
  wire panel_mode_key, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, net_cmd_enable;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp, op_mode;
  integer bad_count, n_compared, i;
  reg [15:0] e;
  reg [31:0] rv;
  reg [1:0] rr;
  somsel_top i_dut (.*);
  somsel_axi_master i_host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      i_host.wr(a, d, rr);
      chk({30'h0, rr}, {30'h0, er});
    end
  endtask
  task rreg(input [7:0] a, input [31:0] ed, input [1:0] er);
    begin
      i_host.rd(a, rv, rr);
      chk(rv, ed);
      chk({30'h0, rr}, {30'h0, er});
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task eval(input restore);
    begin
      @(posedge clk_sys);
      if (restore) power_restore_evt <= 1'b1;
      else power_on_evt <= 1'b1;
      @(posedge clk_sys);
      power_on_evt <= 1'b0;
      power_restore_evt <= 1'b0;
      tick(4);
    end
  endtask
  task mode(input [1:0] m);
    begin
      chk({30'h0, op_mode}, {30'h0, m});
      chk({31'h0, net_cmd_enable}, {31'h0, m == `SOMSEL_OP_NET});
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #200000;
    bad_count = bad_count + 1;
    wrap_up;
  end
  initial begin
    bad_count = 0;
    n_compared = 0;
    srst = 1'b1;
    {power_on_evt, power_restore_evt, drive_running, output_stop_input} = 4'h0;
    {panel_network_switch_input, network_external_switch_input, external_panel_switch_input} = 3'h0;
    tick(3);
    srst <= 1'b0;
    tick(2);
    rreg(`SOMSEL_OFS_MODE_SEL, 32'h0, `SOMSEL_RESP_OKAY);
    rreg(`SOMSEL_OFS_STARTUP, 32'h0, `SOMSEL_RESP_OKAY);
    mode(`SOMSEL_OP_EXT);
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h5, `SOMSEL_RESP_SLVERR);
    wreg(`SOMSEL_OFS_STARTUP, 32'h2, `SOMSEL_RESP_SLVERR);
    rreg(`SOMSEL_OFS_MODE_SEL, 32'h0, `SOMSEL_RESP_OKAY);
    rreg(8'h20, 32'h0, `SOMSEL_RESP_SLVERR);
    drive_running <= 1'b1;
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h1, `SOMSEL_RESP_SLVERR);
    drive_running <= 1'b0;
    rreg(`SOMSEL_OFS_MODE_SEL, 32'h0, `SOMSEL_RESP_OKAY);
    // Startup mode for every setting pair except select 4 under startups 1 and 10, both event kinds
    for (i = 0; i < 21; i = i + 1) begin
      e = TBL[16*i +: 16];
      output_stop_input <= e[3];
      wreg(`SOMSEL_OFS_STARTUP, {24'h0, e[15:8]}, `SOMSEL_RESP_OKAY);
      wreg(`SOMSEL_OFS_MODE_SEL, {28'h0, e[7:4]}, `SOMSEL_RESP_OKAY);
      eval(i[0]);
      mode(e[1:0]);
    end
    wreg(`SOMSEL_OFS_STARTUP, 32'h0, `SOMSEL_RESP_OKAY);
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h0, `SOMSEL_RESP_OKAY);
    eval(1'b0);
    wreg(`SOMSEL_OFS_CTRL, 32'h50, `SOMSEL_RESP_OKAY);
    tick(4);
    mode(`SOMSEL_OP_PANEL);
    i_host.wr(`SOMSEL_OFS_CTRL, 32'h60, rr);
    tick(4);
    mode(`SOMSEL_OP_PANEL);
    rreg(`SOMSEL_OFS_STATUS, 32'h9, `SOMSEL_RESP_OKAY);
    wreg(`SOMSEL_OFS_CTRL, 32'h40, `SOMSEL_RESP_OKAY);
    wreg(`SOMSEL_OFS_CTRL, 32'h60, `SOMSEL_RESP_OKAY);
    tick(4);
    mode(`SOMSEL_OP_NET);
    rreg(`SOMSEL_OFS_STATUS, 32'h6, `SOMSEL_RESP_OKAY);
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h3, `SOMSEL_RESP_OKAY);
    tick(4);
    mode(`SOMSEL_OP_COMB);
    i_host.wr(`SOMSEL_OFS_CTRL, 32'h50, rr);
    tick(4);
    mode(`SOMSEL_OP_COMB);
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h0, `SOMSEL_RESP_OKAY);
    wreg(`SOMSEL_OFS_STARTUP, 32'h0A, `SOMSEL_RESP_OKAY);
    eval(1'b1);
    mode(`SOMSEL_OP_NET);
    wreg(`SOMSEL_OFS_CTRL, 32'h2, `SOMSEL_RESP_OKAY);
    panel_network_switch_input <= 1'b1;
    tick(10);
    mode(`SOMSEL_OP_PANEL);
    panel_network_switch_input <= 1'b0;
    tick(10);
    mode(`SOMSEL_OP_NET);
    wreg(`SOMSEL_OFS_CTRL, 32'h0, `SOMSEL_RESP_OKAY);
    i_host.key_press;
    mode(`SOMSEL_OP_PANEL);
    i_host.key_press;
    mode(`SOMSEL_OP_NET);
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h6, `SOMSEL_RESP_OKAY);
    eval(1'b0);
    drive_running <= 1'b1;
    i_host.key_press;
    mode(`SOMSEL_OP_PANEL);
    wreg(`SOMSEL_OFS_STARTUP, 32'h1, `SOMSEL_RESP_SLVERR);
    drive_running <= 1'b0;
    wreg(`SOMSEL_OFS_STARTUP, 32'h0, `SOMSEL_RESP_OKAY);
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h7, `SOMSEL_RESP_OKAY);
    output_stop_input <= 1'b1;
    tick(6);
    eval(1'b0);
    mode(`SOMSEL_OP_EXT);
    wreg(`SOMSEL_OFS_CTRL, 32'h60, `SOMSEL_RESP_OKAY);
    tick(4);
    mode(`SOMSEL_OP_NET);
    output_stop_input <= 1'b0;
    tick(10);
    mode(`SOMSEL_OP_EXT);
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h2, `SOMSEL_RESP_OKAY);
    wreg(`SOMSEL_OFS_CTRL, 32'h50, `SOMSEL_RESP_OKAY);
    tick(4);
    mode(`SOMSEL_OP_EXT);
    wreg(`SOMSEL_OFS_MODE_SEL, 32'h6, `SOMSEL_RESP_OKAY);
    drive_running <= 1'b1;
    wreg(`SOMSEL_OFS_CTRL, 32'h50, `SOMSEL_RESP_OKAY);
    tick(4);
    mode(`SOMSEL_OP_PANEL);
    drive_running <= 1'b0;
    wreg(`SOMSEL_OFS_CTRL, 32'h4, `SOMSEL_RESP_OKAY);
    network_external_switch_input <= 1'b1;
    tick(10);
    mode(`SOMSEL_OP_NET);
    network_external_switch_input <= 1'b0;
    tick(10);
    mode(`SOMSEL_OP_EXT);
    wreg(`SOMSEL_OFS_CTRL, 32'hC, `SOMSEL_RESP_OKAY);
    tick(4);
    mode(`SOMSEL_OP_PANEL);
    // Mid-run reset clears the settings and starts again in External mode
    srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
    tick(2);
    mode(`SOMSEL_OP_EXT);
    rreg(`SOMSEL_OFS_MODE_SEL, 32'h0, `SOMSEL_RESP_OKAY);
    wrap_up;
  end
endmodule
